//--- hw/hpf_pin_mux.sv
// host pin function control: bus personality, direct pins, host clock
// Notes on behaviour
// [R1] direct modes: select pin low picks ASK, high picks OOK
// [R2] select pin may turn into an output carrying the received signal
// [R3] host drives modulation pin with transmit data in direct modes
// [R4] modulation pin as output shows subcarrier, steered by 0x1A/0x1B
// [R5] parallel mode: all eight bus pins are two-way data lines
// [R6] SPI: pin 4 slave select in, pin 6 MISO out, pin 7 MOSI in
// [R7] direct mode 1: bit clock on pin 5, bit data on pin 6
// [R8] direct mode 0: raw subcarrier on pin 6
// [R9] host supplies the data clock timing every transfer
// [R10] chip enabled: host clock at rate from 0x09, off to 13.56 MHz; the half and full rates both give clk/2 here
// [R11] chip disabled, power-down select high: host clock at 60 kHz
// [R12] chip enable low puts the device to sleep
// [R13] power-down select high keeps auxiliary supply on in power-down
// [R14] host uses one personality and never fights device-driven pins
`timescale 1ns/1ps
module hpf_pin_mux
    import hpf_pkg::*;
#(
    parameter int BUS_W = 8
) (
    // clocks and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             dataClk,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // host bus pins
    input  wire logic [BUS_W-1:0] ioIn,
    output logic      [BUS_W-1:0] ioOut,
    output logic      [BUS_W-1:0] ioOe,
    // modulation select and modulation data pins
    input  wire logic             modSelIn,
    output logic                  modSelOut,
    output logic                  modSelOe,
    input  wire logic             modDataIn,
    output logic                  modDataOut,
    output logic                  modDataOe,
    // core side
    input  wire logic             rxAnalog,
    input  wire logic             subcarrier,
    input  wire logic             bitClock,
    input  wire logic             bitData,
    output logic                  txModData,
    output logic                  txOokSel,
    // power
    input  wire logic             chipEn,
    input  wire logic             powerDownSel,
    output logic                  hostClkOut,
    output logic                  sleepMode,
    output logic                  auxSupplyOn
);

    function automatic logic hpf_mapped(input logic [7:0] a);
        return a == {IDX_IF_CTRL, 2'b00} || a == {IDX_CLK_CTRL, 2'b00}
            || a == {IDX_MODPIN, 2'b00} || a == {IDX_SUBC, 2'b00}
            || a == {IDX_REPLY, 2'b00} || a == {IDX_STATUS, 2'b00};
    endfunction : hpf_mapped

    logic [4:0]       pinS1_reg;
    logic [4:0]       pinS2_reg;
    logic             chipEnS;
    logic             pdSelS;
    logic             modSelS;
    logic             modDataS;
    logic             ssS;
    logic [3:0]       ifCtrl_reg;
    logic [1:0]       clkRate_reg;
    logic             modPin_reg;
    logic             subcInv_reg;
    logic [7:0]       reply_reg;
    logic             replyTog_reg;
    logic [7:0]       rxByte_reg;
    logic [7:0]       rxCount_reg;
    logic             ready_reg;
    logic [31:0]      prdata_reg;
    logic             slverr_reg;
    logic [BUS_W-1:0] ioOutSys_reg;
    logic [BUS_W-1:0] ioOe_reg;
    logic             spiOut_reg;
    logic             selOut_reg;
    logic             selOe_reg;
    logic             modOut_reg;
    logic             modOe_reg;
    logic             txMod_reg;
    logic             txOok_reg;
    logic             sleep_reg;
    logic             aux_reg;
    logic             hclk_reg;
    logic [7:0]       hcnt_reg;
    logic [7:0]       half_next;
    logic             hrun_next;
    logic             rxTogS1_reg;
    logic             rxTogS2_reg;
    logic             rxTogS3_reg;
    logic             access;
    logic             doWrite;
    logic             direct;
    logic [31:0]      rdata_next;
    hpf_mode_type     mode;
    // link domain
    logic [1:0]       modeL1_reg;
    logic [1:0]       modeL2_reg;
    logic             repTogL1_reg;
    logic             repTogL2_reg;
    logic             repTogL3_reg;
    logic [7:0]       replyL_reg;
    logic [6:0]       shiftL_reg;
    logic [2:0]       bitCntL_reg;
    logic [7:0]       misoSh_reg;
    logic             miso_reg;
    logic [7:0]       rxByteL_reg;
    logic             rxTogL_reg;

    assign {chipEnS, pdSelS, modSelS, modDataS, ssS} = pinS2_reg;
    assign mode = hpf_mode_type'(ifCtrl_reg[1:0]);
    assign direct = mode == MODE_DIRECT0 || mode == MODE_DIRECT1;
    assign access = psel && penable;
    assign doWrite = access && ready_reg && pwrite;

    // control pins pass two flops before any clk logic; the link logic samples the bus pins directly
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinS1_reg <= 5'h00;
            pinS2_reg <= 5'h00;
        end else begin
            pinS1_reg <= {chipEn, powerDownSel, modSelIn, modDataIn,
                          ioIn[PIN_SS]};
            pinS2_reg <= pinS1_reg;
        end
    end

    // apb: one wait state so read data leaves a flop
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (paddr)
            {IDX_IF_CTRL, 2'b00}: rdata_next[3:0] = ifCtrl_reg;
            {IDX_CLK_CTRL, 2'b00}: rdata_next[1:0] = clkRate_reg;
            {IDX_MODPIN, 2'b00}: rdata_next[0] = modPin_reg;
            {IDX_SUBC, 2'b00}: rdata_next[0] = subcInv_reg;
            {IDX_REPLY, 2'b00}: rdata_next[7:0] = reply_reg;
            {IDX_STATUS, 2'b00}: rdata_next[18:0] =
                {sleep_reg, pdSelS, chipEnS, rxCount_reg, rxByte_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            slverr_reg <= 1'b0;
        end else begin
            ready_reg <= access && !ready_reg;
            if (access && !ready_reg) begin
                prdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
                slverr_reg <= !hpf_mapped(paddr);
            end
        end
    end

    // writes land only on the edge where pready is sampled high
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ifCtrl_reg <= IF_CTRL_RST;
            clkRate_reg <= CLK_RATE_RST;
            modPin_reg <= 1'b0;
            subcInv_reg <= 1'b0;
            reply_reg <= 8'h00;
            replyTog_reg <= 1'b0;
        end else if (doWrite) begin
            case (paddr)
                {IDX_IF_CTRL, 2'b00}: ifCtrl_reg <= pwdata[3:0];
                {IDX_CLK_CTRL, 2'b00}: clkRate_reg <= pwdata[1:0]; // [R10]
                {IDX_MODPIN, 2'b00}: modPin_reg <= pwdata[0]; // [R4]
                {IDX_SUBC, 2'b00}: subcInv_reg <= pwdata[0]; // [R4]
                {IDX_REPLY, 2'b00}: begin
                    reply_reg <= pwdata[7:0];
                    replyTog_reg <= !replyTog_reg;
                end
                default: ifCtrl_reg <= ifCtrl_reg;
            endcase
        end
    end

    // received bytes come back by toggle; data is stable by then
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxTogS1_reg <= 1'b0;
            rxTogS2_reg <= 1'b0;
            rxTogS3_reg <= 1'b0;
            rxByte_reg <= 8'h00;
            rxCount_reg <= 8'h00;
        end else begin
            rxTogS1_reg <= rxTogL_reg;
            rxTogS2_reg <= rxTogS1_reg;
            rxTogS3_reg <= rxTogS2_reg;
            if (rxTogS2_reg != rxTogS3_reg) begin
                rxByte_reg <= rxByteL_reg;
                rxCount_reg <= rxCount_reg + 8'h01;
            end
        end
    end

    // pin personalities; pins not listed stay undriven
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ioOutSys_reg <= '0;
            ioOe_reg <= '0;
            spiOut_reg <= 1'b0;
        end else begin
            ioOutSys_reg <= '0;
            ioOe_reg <= '0;
            spiOut_reg <= 1'b0;
            case (mode)
                MODE_PARALLEL: begin
                    ioOutSys_reg <= reply_reg; // [R5]
                    if (ifCtrl_reg[IF_PAR_DRV_BIT]) begin
                        ioOe_reg <= '1; // [R5]
                    end
                end
                MODE_SPI: begin
                    spiOut_reg <= 1'b1;
                    ioOe_reg[PIN_MISO] <= !ssS; // [R6]
                end
                MODE_DIRECT0: begin
                    ioOutSys_reg[PIN_MISO] <= subcarrier; // [R8]
                    ioOe_reg[PIN_MISO] <= 1'b1; // [R8]
                end
                MODE_DIRECT1: begin
                    ioOutSys_reg[PIN_BCLK] <= bitClock; // [R7]
                    ioOutSys_reg[PIN_MISO] <= bitData; // [R7]
                    ioOe_reg[PIN_MISO:PIN_BCLK] <= 2'b11; // [R7]
                end
                default: ioOe_reg <= '0;
            endcase
        end
    end

    // miso must follow the data clock, so it bypasses the pin flops
    always_comb begin
        ioOut = ioOutSys_reg;
        if (spiOut_reg) begin
            ioOut[PIN_MISO] = miso_reg; // [R6]
        end
    end
    assign ioOe = ioOe_reg;

    // modulation select and modulation data pins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            selOut_reg <= 1'b0;
            selOe_reg <= 1'b0;
            modOut_reg <= 1'b0;
            modOe_reg <= 1'b0;
            txMod_reg <= 1'b0;
            txOok_reg <= 1'b0;
        end else begin
            selOut_reg <= rxAnalog; // [R2]
            selOe_reg <= ifCtrl_reg[IF_SEL_OUT_BIT]; // [R2]
            modOut_reg <= subcarrier ^ subcInv_reg; // [R4]
            modOe_reg <= modPin_reg; // [R4]
            // an output select pin cannot also choose, so fall back to ASK
            txOok_reg <= direct && !ifCtrl_reg[IF_SEL_OUT_BIT]
                         && modSelS; // [R1]
            txMod_reg <= direct && !modPin_reg && modDataS; // [R3]
        end
    end

    assign modSelOut = selOut_reg;
    assign modSelOe = selOe_reg;
    assign modDataOut = modOut_reg;
    assign modDataOe = modOe_reg;
    assign txOokSel = txOok_reg;
    assign txModData = txMod_reg;

    // power state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sleep_reg <= 1'b1;
            aux_reg <= 1'b0;
        end else begin
            sleep_reg <= !chipEnS; // [R12]
            aux_reg <= chipEnS || pdSelS; // [R13]
        end
    end
    assign sleepMode = sleep_reg;
    assign auxSupplyOn = aux_reg;

    // host clock divider; the fast rates saturate at clk/2 here
    always_comb begin
        half_next = HALF_SLEEP;
        hrun_next = 1'b0;
        if (chipEnS) begin
            hrun_next = clkRate_reg != CLK_OFF; // [R10]
            case (clkRate_reg)
                CLK_QUART: half_next = HALF_QUART;
                CLK_HALF: half_next = HALF_HALF;
                CLK_FULL: half_next = HALF_FULL;
                default: half_next = HALF_FULL;
            endcase
        end else if (pdSelS) begin
            hrun_next = 1'b1; // [R11]
            half_next = HALF_SLEEP; // [R11]
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hcnt_reg <= 8'h00;
            hclk_reg <= 1'b0;
        end else if (!hrun_next) begin
            hcnt_reg <= 8'h00;
            hclk_reg <= 1'b0;
        end else if (hcnt_reg >= half_next - 8'h01) begin
            hcnt_reg <= 8'h00;
            hclk_reg <= !hclk_reg;
        end else begin
            hcnt_reg <= hcnt_reg + 8'h01;
        end
    end
    assign hostClkOut = hclk_reg;

    // data clock domain: the host's data clock times every transfer
    always_ff @(posedge dataClk or posedge sys_rst) begin
        if (sys_rst) begin
            modeL1_reg <= 2'h0;
            modeL2_reg <= 2'h0;
            repTogL1_reg <= 1'b0;
            repTogL2_reg <= 1'b0;
            repTogL3_reg <= 1'b0;
            replyL_reg <= 8'h00;
        end else begin
            modeL1_reg <= ifCtrl_reg[1:0];
            modeL2_reg <= modeL1_reg;
            repTogL1_reg <= replyTog_reg;
            repTogL2_reg <= repTogL1_reg;
            repTogL3_reg <= repTogL2_reg;
            if (repTogL2_reg != repTogL3_reg) begin
                replyL_reg <= reply_reg;
            end
        end
    end

    always_ff @(posedge dataClk or posedge sys_rst) begin
        if (sys_rst) begin
            shiftL_reg <= 7'h00;
            bitCntL_reg <= 3'h0;
            misoSh_reg <= 8'h00;
            miso_reg <= 1'b0;
            rxByteL_reg <= 8'h00;
            rxTogL_reg <= 1'b0;
        end else if (modeL2_reg == MODE_PARALLEL) begin
            rxByteL_reg <= ioIn; // [R9]
            rxTogL_reg <= !rxTogL_reg; // [R9]
        end else if (modeL2_reg == MODE_SPI) begin
            if (ioIn[PIN_SS]) begin
                bitCntL_reg <= 3'h0;
                misoSh_reg <= replyL_reg;
                miso_reg <= replyL_reg[7];
            end else begin
                shiftL_reg <= {shiftL_reg[5:0], ioIn[PIN_MOSI]}; // [R6]
                bitCntL_reg <= bitCntL_reg + 3'h1;
                if (bitCntL_reg == 3'h7) begin
                    rxByteL_reg <= {shiftL_reg, ioIn[PIN_MOSI]}; // [R9]
                    rxTogL_reg <= !rxTogL_reg;
                    misoSh_reg <= replyL_reg;
                    miso_reg <= replyL_reg[7];
                end else begin
                    misoSh_reg <= {misoSh_reg[6:0], 1'b0};
                    miso_reg <= misoSh_reg[6]; // [R6]
                end
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = ready_reg;
    assign pslverr = slverr_reg;

    AST_OOK_SEL: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
        (direct && !ifCtrl_reg[IF_SEL_OUT_BIT])[*4]
        |-> txOokSel == $past(modSelIn, 3))
        else $error("ook select does not follow select pin");
    AST_ANALOG_OUT: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
        ifCtrl_reg[IF_SEL_OUT_BIT] |=> modSelOe && modSelOut == $past(rxAnalog))
        else $error("select pin not presenting received signal");
    AST_MOD_IN: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
        (direct && !modPin_reg)[*4] |-> txModData == $past(modDataIn, 3))
        else $error("transmit data does not follow modulation pin");
    AST_SUBC_OUT: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
        modPin_reg |=> modDataOe
        && modDataOut == ($past(subcarrier) ^ $past(subcInv_reg)))
        else $error("modulation pin not showing subcarrier");
    AST_PAR_OE: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
        mode == MODE_PARALLEL && ifCtrl_reg[IF_PAR_DRV_BIT]
        |=> ioOe == '1 && ioOut == $past(reply_reg))
        else $error("parallel bus not driven");
    AST_SPI_PINS: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
        mode == MODE_SPI |=> !ioOe[PIN_SS] && !ioOe[PIN_MOSI]
        && ioOe[PIN_MISO] == !$past(ssS))
        else $error("spi pin directions wrong");
    AST_DIRECT1: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
        mode == MODE_DIRECT1 |=> ioOe[PIN_BCLK] && ioOe[PIN_MISO]
        && ioOut[PIN_BCLK] == $past(bitClock)
        && ioOut[PIN_MISO] == $past(bitData))
        else $error("direct mode 1 outputs wrong");
    AST_DIRECT0: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
        mode == MODE_DIRECT0 |=> ioOe[PIN_MISO] && !ioOe[PIN_BCLK]
        && ioOut[PIN_MISO] == $past(subcarrier))
        else $error("direct mode 0 subcarrier missing");
    AST_CLK_OFF: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
        (chipEnS && clkRate_reg == CLK_OFF)[*2] |-> !hostClkOut)
        else $error("host clock runs while off");
    AST_SLOW_CLK: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
        $rose(hostClkOut) && !chipEnS && pdSelS ##1 (!chipEnS && pdSelS)
        [*8] |-> $stable(hostClkOut))
        else $error("sleep host clock too fast");
    AST_SLEEP: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
        !chipEn [*4] |-> sleepMode)
        else $error("not asleep with chip enable low");
    AST_AUX: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
        (!chipEn && powerDownSel)[*4] |-> auxSupplyOn && sleepMode)
        else $error("aux supply off in power-down");

    COV_SPI: cover property (@(posedge clk) disable iff (sys_rst)
        mode == MODE_SPI && rxTogS2_reg != rxTogS3_reg);
    COV_PAR: cover property (@(posedge clk) disable iff (sys_rst)
        mode == MODE_PARALLEL && ioOe == '1);
    COV_DIR1: cover property (@(posedge clk) disable iff (sys_rst)
        mode == MODE_DIRECT1 && txOokSel);
    COV_SLOW: cover property (@(posedge clk) disable iff (sys_rst)
        !chipEnS && pdSelS && $rose(hostClkOut));

endmodule : hpf_pin_mux

//--- inc/hpf_pkg.sv
// constants and types for the host pin function block
package hpf_pkg;
    localparam int HOST_CLOCK_OUTPUT_HZ = 20_000_000;
    localparam int HCLK_FULL_HZ = 13_560_000;
    localparam int HCLK_HALF_HZ = 6_780_000;
    localparam int HCLK_QUART_HZ = 3_390_000;
    localparam int HCLK_SLEEP_HZ = 60_000;

    // half period in clk cycles, rounded down, never below one
    function automatic logic [7:0] hpf_half_cnt(input int hz);
        int c;
        c = HOST_CLOCK_OUTPUT_HZ / (2 * hz);
        if (c < 1) begin
            c = 1;
        end
        return c[7:0];
    endfunction : hpf_half_cnt

    localparam logic [7:0] HALF_FULL = hpf_half_cnt(HCLK_FULL_HZ);
    localparam logic [7:0] HALF_HALF = hpf_half_cnt(HCLK_HALF_HZ);
    localparam logic [7:0] HALF_QUART = hpf_half_cnt(HCLK_QUART_HZ);
    localparam logic [7:0] HALF_SLEEP = hpf_half_cnt(HCLK_SLEEP_HZ);

    localparam logic [5:0] IDX_IF_CTRL = 6'h01;
    localparam logic [5:0] IDX_CLK_CTRL = 6'h09;
    localparam logic [5:0] IDX_MODPIN = 6'h1a;
    localparam logic [5:0] IDX_SUBC = 6'h1b;
    localparam logic [5:0] IDX_REPLY = 6'h1f;
    localparam logic [5:0] IDX_STATUS = 6'h30;

    localparam int IF_SEL_OUT_BIT = 2;
    localparam int IF_PAR_DRV_BIT = 3;
    localparam logic [3:0] IF_CTRL_RST = 4'h0;
    localparam logic [1:0] CLK_RATE_RST = 2'h3;
    localparam logic [1:0] CLK_OFF = 2'h0;
    localparam logic [1:0] CLK_QUART = 2'h1;
    localparam logic [1:0] CLK_HALF = 2'h2;
    localparam logic [1:0] CLK_FULL = 2'h3;

    localparam int PIN_SS = 4;
    localparam int PIN_BCLK = 5;
    localparam int PIN_MISO = 6;
    localparam int PIN_MOSI = 7;

    typedef enum logic [1:0] {
        MODE_PARALLEL = 2'h0,
        MODE_SPI      = 2'h1,
        MODE_DIRECT0  = 2'h2,
        MODE_DIRECT1  = 2'h3
    } hpf_mode_type;
endpackage : hpf_pkg

//--- dv/hpf_host_model.sv
// host microcontroller model: data clock and bus pins
`timescale 1ns/1ps
module hpf_host_model (
    // link clock and pins
    output logic             dataClk,
    output logic [7:0]       hostOut,
    input  wire  logic [7:0] pinLevel
);
    initial begin
        dataClk = 1'b0;
        hostOut = 8'hef;
    end
    // 12 ns data clock, still between frames
    task automatic pulse;
        #6 dataClk = 1'b1;
        #6 dataClk = 1'b0;
    endtask : pulse
    // released lines flip so no stale value passes, select stays high
    task automatic letGo;
        hostOut = ~hostOut | 8'h10;
    endtask : letGo
    task automatic parFrame(input logic [7:0] b);
        hostOut = b;
        pulse();
        letGo();
    endtask : parFrame
    task automatic spiFrame(input logic [7:0] b, output logic [7:0] miso);
        int i;
        hostOut[4] = 1'b1;
        // reply lands on the third link edge, the shifter loads on the fourth
        repeat (4) pulse();
        hostOut[4] = 1'b0;
        #200;
        for (i = 7; i >= 0; i--) begin
            hostOut[7] = b[i];
            miso[i] = pinLevel[6];
            pulse();
        end
        hostOut[4] = 1'b1;
        letGo();
    endtask : spiFrame
endmodule : hpf_host_model

//--- dv/tb_host_pin_function_control.sv
// self-checking bench for the host pin function block
`timescale 1ns/1ps
module tb_host_pin_function_control;
    import hpf_pkg::*;
    typedef struct packed {
        logic [3:0] ctrl;
        logic [4:0] pins;
        logic [7:0] oe;
        logic [7:0] out;
        logic [1:0] tx;
    } hpf_row_type;
    logic        clk, sys_rst, dataClk, psel, penable, pwrite;
    logic [7:0]  paddr, ioIn, ioOut, ioOe, hostOut, miso, h;
    logic [31:0] pwdata, prdata, rdata;
    logic        pready, pslverr, rerr, modSelIn, modSelOut, modSelOe;
    logic        modDataIn, modDataOut, modDataOe, rxAnalog, subcarrier;
    logic        bitClock, bitData, txModData, txOokSel, chipEn;
    logic        powerDownSel, hostClkOut, sleepMode, auxSupplyOn;
    hpf_row_type rows[7];
    logic [11:0] clks[6];
    int          fails, samplesChecked, i;

    hpf_pin_mux uut (
        .clk, .sys_rst, .dataClk, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ioIn, .ioOut, .ioOe,
        .modSelIn, .modSelOut, .modSelOe, .modDataIn, .modDataOut,
        .modDataOe, .rxAnalog, .subcarrier, .bitClock, .bitData,
        .txModData, .txOokSel, .chipEn, .powerDownSel, .hostClkOut,
        .sleepMode, .auxSupplyOn
    );
    hpf_host_model host (.dataClk(dataClk), .hostOut(hostOut),
        .pinLevel(ioIn));
    assign ioIn = (ioOe & ioOut) | (~ioOe & hostOut);
    always #25 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("compares %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            complete_run();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // bounded: a stuck clock gives 00 when low and ff when high
    task automatic measure(output logic [7:0] hv);
        int n;
        logic last;
        last = hostClkOut;
        n = 0;
        while (hostClkOut === last && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) hv = last ? 8'hff : 8'h00;
        else begin
            last = hostClkOut;
            n = 0;
            while (hostClkOut === last && n < 400) begin
                @(posedge clk);
                n++;
            end
            hv = n[7:0];
        end
    endtask : measure

    initial begin
        rows[0] = {4'h8, 5'h03, 8'hff, 8'ha5, 2'h0};
        rows[1] = {4'h0, 5'h03, 8'h00, 8'h00, 2'h0};
        rows[2] = {4'h1, 5'h03, 8'h00, 8'h00, 2'h0};
        rows[3] = {4'h2, 5'h11, 8'h40, 8'h40, 2'h1};
        rows[4] = {4'h2, 5'h02, 8'h40, 8'h00, 2'h2};
        rows[5] = {4'h3, 5'h1b, 8'h60, 8'h20, 2'h3};
        rows[6] = {4'h3, 5'h04, 8'h60, 8'h40, 2'h0};
        clks = '{12'hb01, 12'hd02, 12'ha01, 12'h800, 12'h7a6, 12'h300};
        {clk, psel, penable, pwrite, paddr, pwdata} = '0;
        {modSelIn, modDataIn, rxAnalog, subcarrier, bitClock} = '0;
        {bitData, powerDownSel, fails, samplesChecked} = '0;
        chipEn = 1'b1;
        sys_rst = 1'b1;
        cyc(3);
        sys_rst <= 1'b0;
        cyc(4);
        apb(1'b0, 8'h04, 32'h0);
        chk(rdata, 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        chk(rdata, 32'h3);
        apb(1'b0, 8'h08, 32'h0);
        chk({rdata[30:0], rerr}, 32'h1);
        host.parFrame(8'h5e);
        cyc(8);
        apb(1'b0, 8'hc0, 32'h0);
        chk(rdata, 32'h0001015e);
        $display("reset and parallel capture done");
        apb(1'b1, 8'h7c, 32'ha5);
        // let the link see this reply before the next one toggles it back
        repeat (3) host.pulse();
        for (i = 0; i < 7; i++) begin
            {subcarrier, bitClock, bitData, modSelIn, modDataIn} <=
                rows[i].pins;
            apb(1'b1, 8'h04, {28'h0, rows[i].ctrl});
            cyc(5);
            chk(32'(ioOe), 32'(rows[i].oe));
            chk(32'(ioOut & ioOe), 32'(rows[i].out));
            chk(32'({txOokSel, txModData}), 32'(rows[i].tx));
            $display("row %0d done", i);
        end
        rxAnalog <= 1'b1;
        modSelIn <= 1'b1;
        apb(1'b1, 8'h04, 32'h6);
        cyc(5);
        chk(32'({modSelOe, modSelOut, txOokSel}), 32'h6);
        rxAnalog <= 1'b0;
        subcarrier <= 1'b1;
        modDataIn <= 1'b1;
        apb(1'b1, 8'h68, 32'h1);
        apb(1'b1, 8'h6c, 32'h1);
        cyc(5);
        chk(32'({modSelOut, modDataOe, modDataOut, txModData}),
            32'h4);
        subcarrier <= 1'b0;
        cyc(4);
        chk(32'(modDataOut), 32'h1);
        $display("select and modulation pin outputs done");
        apb(1'b1, 8'h7c, 32'h3c);
        apb(1'b1, 8'h04, 32'h1);
        host.spiFrame(8'ha7, miso);
        chk(32'(miso), 32'h3c);
        cyc(8);
        apb(1'b0, 8'hc0, 32'h0);
        chk(32'(rdata[7:0]), 32'ha7);
        $display("serial transfer done");
        for (i = 0; i < 6; i++) begin
            chipEn <= clks[i][11];
            powerDownSel <= clks[i][10];
            apb(1'b1, 8'h24, {30'h0, clks[i][9:8]});
            cyc(6);
            measure(h);
            chk(32'(h), 32'(clks[i][7:0]));
            chk(32'({sleepMode, auxSupplyOn}),
                32'({~clks[i][11], |clks[i][11:10]}));
            $display("host clock case %0d done", i);
        end
        complete_run();
    end
endmodule : tb_host_pin_function_control
